// >>> rtl/i2sf_pkg.sv
// i2sf_pkg: constants shared by the two-wire status flag block.
// assumes: AXI4-Lite register bus with 32-bit data and byte addresses.
package i2sf_pkg;

   // ======================================================
   // register byte offsets
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  OFF_STATUS_ONE = 8'h00; // read only flags
   localparam logic [7:0]  OFF_STATUS_TWO = 8'h04; // error flags, read clears
   localparam logic [7:0]  OFF_CONTROL    = 8'h08; // interface on, irq enable
   localparam logic [7:0]  OFF_DATA       = 8'h0C; // data byte register
   localparam logic [7:0]  OFF_IRQ_STAT   = 8'h10; // sticky events, write one clears
   localparam logic [7:0]  OFF_IRQ_MASK   = 8'h14; // mask, same layout
   localparam logic [7:0]  OFF_OWN_ADDR   = 8'h18; // own slave address

   // ======================================================
   // status_one bit positions
   localparam int unsigned S1_EVENT  = 7;
   localparam int unsigned S1_HDR    = 6;
   localparam int unsigned S1_DIR    = 5;
   localparam int unsigned S1_BUSY   = 4;
   localparam int unsigned S1_BTF    = 3;
   localparam int unsigned S1_OWN_ADDRESS_MATCHED   = 2;
   localparam int unsigned S1_MASTER = 1;
   localparam int unsigned S1_START  = 0;

   // status_two bit positions
   localparam int unsigned S2_BUSERR = 0;
   localparam int unsigned S2_ARBLOST = 1;
   localparam int unsigned S2_STOP   = 2;
   localparam int unsigned S2_NOACK  = 3;

   // control bit positions
   localparam int unsigned CTL_ON  = 0;
   localparam int unsigned CTL_ITE = 1;

   // irq status / mask bit positions
   localparam int unsigned IRQ_BTF    = 0;
   localparam int unsigned IRQ_OWN_ADDRESS_MATCHED   = 1;
   localparam int unsigned IRQ_START  = 2;
   localparam int unsigned IRQ_NOACK  = 3;
   localparam int unsigned IRQ_STOP   = 4;
   localparam int unsigned IRQ_ARB    = 5;
   localparam int unsigned IRQ_BUSERR = 6;
   localparam int unsigned IRQ_HDR    = 7;

   // ======================================================
   // reset values and fixed codes
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [6:0] RST_OWN_ADDR = 7'h00;
   localparam logic [6:0] GENERAL_CALL = 7'h00;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage

// >>> rtl/i2sf_line_if.sv
// i2sf_line_if: synchronised bus line levels and conditions.
// assumes: driven by the line monitor, read by the flag logic, one clock.
`timescale 1ns/1ps
`default_nettype none

interface i2sf_line_if;
   logic sclLevel;  // clock line after synchroniser
   logic sdaLevel;  // data line after synchroniser
   logic startSeen; // one-cycle pulse, start condition
   logic stopSeen;  // one-cycle pulse, stop condition

   modport mon  (output sclLevel, output sdaLevel, output startSeen, output stopSeen);
   modport user (input sclLevel, input sdaLevel, input startSeen, input stopSeen);
endinterface

`default_nettype wire

// >>> rtl/i2sf_line_monitor.sv
// i2sf_line_monitor: synchronises the two bus lines, finds start and stop.
// assumes: lines are asynchronous to clock and far slower than it.
`timescale 1ns/1ps
`default_nettype none

module i2sf_line_monitor
   import i2sf_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   i2sf_line_if.mon  line
);

   // ======================================================
   // state
   typedef struct packed {
      logic [1:0] sclSync; // [0] first stage, read only by [1]
      logic [1:0] sdaSync;
      logic       sclPrev; // third stage, safe for edge compare
      logic       sdaPrev;
      logic       start;
      logic       stop;
   } i2sf_mon_t;

   i2sf_mon_t q;
   i2sf_mon_t d;

   // next state: start is data falling while clock high, stop is data rising
   always_comb
   begin
      d            = q;
      d.sclSync    = {q.sclSync[0], sclIn};
      d.sdaSync    = {q.sdaSync[0], sdaIn};
      d.sclPrev    = q.sclSync[1];
      d.sdaPrev    = q.sdaSync[1];
      d.start      = q.sclSync[1] && q.sclPrev && q.sdaPrev && !q.sdaSync[1];
      d.stop       = q.sclSync[1] && q.sclPrev && !q.sdaPrev && q.sdaSync[1];
   end

   // registers; idle bus reads high after reset
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         q <= '{sclSync: 2'h3, sdaSync: 2'h3, sclPrev: 1'b1, sdaPrev: 1'b1,
                start: 1'b0, stop: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   assign line.sclLevel  = q.sclPrev;
   assign line.sdaLevel  = q.sdaPrev;
   assign line.startSeen = q.start;
   assign line.stopSeen  = q.stop;

endmodule

`default_nettype wire

// >>> rtl/i2sf_status_flags.sv
// i2sf_status_flags: status_one flag logic of a two-wire bus interface,
// with AXI4-Lite registers, interrupt and clock-stretch drive.
// assumes: the byte engine on the same clock gives one-cycle event pulses;
// bus lines arrive raw and are synchronised inside.
// Operation
// - any interrupt source or address sent sets the event flag
// - status_two read clears event after errors
// - interface off clears event, header, direction, btf, own_address_matched
// - header flag cleared by status_two read, data write
// - direction valid with btf, cleared with it
// - stop or arbitration loss clears direction
// - start sets busy, stop clears busy
// - bus error clears busy
// - busy frozen while interface off
// - byte done sets btf, interrupt if enabled
// - tx btf after ack, address after phase event
// - tx btf cleared by status read, data write
// - rx btf after ack; cleared status read, data read
// - clock held low while btf set
// - address match or general call sets own_address_matched
// - status_one read clears own_address_matched; clock held low
// - status_one read only, reset zero, fixed layout
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module i2sf_status_flags
   import i2sf_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // bus lines; clock line is open drain
   input  wire logic              sclIn,
   input  wire logic              sdaIn,
   output logic                   sclOut,
   output logic                   sclOe,
   // byte engine events, one-cycle pulses, with their data and qualifier levels
   input  wire logic              engStartGen,
   input  wire logic              engNoAck,
   input  wire logic              engArbLost,
   input  wire logic              engBusErr,
   input  wire logic              engHdrSent,
   input  wire logic              engAddrSent,
   input  wire logic              engTxDone,
   input  wire logic              engTxIsAddr,
   input  wire logic              engRxDone,
   input  wire logic [7:0]        engRxData,
   input  wire logic              engAckEn,
   input  wire logic              engRxAddrValid,
   input  wire logic [6:0]        engRxAddr,
   // to the byte engine, and the interrupt line
   output logic                   interfaceOn,
   output logic [7:0]             txByte,
   output logic                   dataWrStrobe,
   output logic                   dataRdStrobe,
   output logic                   irq
);

   // ======================================================
   // line monitor
   i2sf_line_if line ();

   i2sf_line_monitor u_mon (
      .clock (clock),
      .rst   (rst),
      .sclIn (sclIn),
      .sdaIn (sdaIn),
      .line  (line)
   );

   // ======================================================
   // all state in one struct
   typedef struct packed {
      logic              awRdy;     // bus handshake registers
      logic              wRdy;
      logic              arRdy;
      logic              awHave;
      logic              wHave;
      logic [ADDR_W-1:0] awAddr;
      logic [7:0]        wByte;
      logic              wLane0;
      logic              bValid;
      logic [1:0]        bResp;
      logic              rValid;
      logic [31:0]       rData;
      logic [1:0]        rResp;
      logic [7:0]        stOne;     // status_one flags
      logic [3:0]        stTwo;     // error flags
      logic              ifOn;      // interface_on_bit
      logic              intEn;     // interrupt_enable_bit
      logic [6:0]        ownAddr;
      logic [7:0]        dataByte;
      logic              wrPulse;
      logic              rdPulse;
      logic              seqArmed;  // status_one read seen last
      logic              hdrArmed;  // status_two read seen last
      logic [7:0]        irqSt;
      logic [7:0]        irqMask;
      logic              irqOut;
      logic              sclHold;
   } i2sf_state_t;

   i2sf_state_t q;
   i2sf_state_t d;

   // ======================================================
   // next state
   always_comb
   begin
      logic       wrEn;
      logic       rdEn;
      logic       rdS1;
      logic       rdS2;
      logic       rdDr;
      logic       wrDr;
      logic       btfSet;
      logic       btfClr;
      logic       adslSet;
      logic       stopSlave;
      logic       evtClr;
      logic [7:0] irqSet;
      logic [31:0] rv;
      logic       mapped;
      wrEn      = 1'b0;
      rdEn      = 1'b0;
      rdS1      = 1'b0;
      rdS2      = 1'b0;
      rdDr      = 1'b0;
      wrDr      = 1'b0;
      btfSet    = 1'b0;
      btfClr    = 1'b0;
      adslSet   = 1'b0;
      stopSlave = 1'b0;
      evtClr    = 1'b0;
      irqSet    = 8'h00;
      rv        = 32'h0000_0000;
      mapped    = 1'b1;
      d         = q;
      d.wrPulse = 1'b0;
      d.rdPulse = 1'b0;

      // write channels taken in either order
      if (awvalid && q.awRdy)
      begin
         d.awHave = 1'b1;
         d.awAddr = awaddr;
      end
      if (wvalid && q.wRdy)
      begin
         d.wHave  = 1'b1;
         d.wByte  = wdata[7:0];
         d.wLane0 = wstrb[0];
      end
      // response accepted
      if (q.bValid && bready)
         d.bValid = 1'b0;
      if (q.rValid && rready)
         d.rValid = 1'b0;
      // write commits once both halves are held and no response waits
      if (q.awHave && q.wHave && !q.bValid)
      begin
         wrEn     = 1'b1;
         d.awHave = 1'b0;
         d.wHave  = 1'b0;
         d.bValid = 1'b1;
         d.bResp  = RESP_OKAY;
         case (q.awAddr)
            OFF_CONTROL:
               if (q.wLane0)
               begin
                  d.ifOn  = q.wByte[CTL_ON];
                  d.intEn = q.wByte[CTL_ITE];
               end
            OFF_DATA:
            begin
               wrDr = 1'b1;
               if (q.wLane0)
               begin
                  d.dataByte = q.wByte;
                  d.wrPulse  = 1'b1;
               end
            end
            OFF_IRQ_MASK:
               if (q.wLane0)
                  d.irqMask = q.wByte;
            OFF_OWN_ADDR:
               if (q.wLane0)
                  d.ownAddr = q.wByte[6:0];
            // read-only or write-one-clear, handled below
            OFF_STATUS_ONE, OFF_STATUS_TWO, OFF_IRQ_STAT: ;
            default: d.bResp = RESP_SLVERR; // unmapped address
         endcase
      end

      // read: one outstanding, data registered with rvalid
      if (arvalid && q.arRdy)
      begin
         rdEn = 1'b1;
         case (araddr)
            OFF_STATUS_ONE: begin rv[7:0] = q.stOne; rdS1 = 1'b1; end
            OFF_STATUS_TWO: begin rv[3:0] = q.stTwo; rdS2 = 1'b1; end
            OFF_CONTROL:    begin rv[CTL_ON] = q.ifOn; rv[CTL_ITE] = q.intEn; end
            OFF_DATA:       begin rv[7:0] = q.dataByte; rdDr = 1'b1; end
            OFF_IRQ_STAT:   rv[7:0] = q.irqSt;
            OFF_IRQ_MASK:   rv[7:0] = q.irqMask;
            OFF_OWN_ADDR:   rv[6:0] = q.ownAddr;
            default:        mapped = 1'b0;
         endcase
         d.rValid = 1'b1;
         d.rData  = rv;
         d.rResp  = mapped ? RESP_OKAY : RESP_SLVERR;
         d.rdPulse = rdDr;
      end

      // ordered clear sequences use the armed state from before this cycle
      btfClr = q.seqArmed && q.stOne[S1_BTF]
               && ((rdDr && !q.stOne[S1_DIR])
                   || (wrDr && q.stOne[S1_DIR]));
      // only the access right after the status read completes a pair
      if (rdS1)
         d.seqArmed = 1'b1;
      else if (wrEn || rdEn)
         d.seqArmed = 1'b0;
      if (rdS2)
         d.hdrArmed = 1'b1;
      else if (wrEn || rdEn)
         d.hdrArmed = 1'b0;

      // ---- clears first, so that a same-cycle set wins ----
      if (btfClr)
      begin
         d.stOne[S1_BTF] = 1'b0;
         d.stOne[S1_DIR] = 1'b0;
      end
      if (rdS1)
         d.stOne[S1_OWN_ADDRESS_MATCHED] = 1'b0;
      if (q.seqArmed && wrDr)
         d.stOne[S1_START] = 1'b0; // address written after start
      if (q.hdrArmed && wrDr)
         d.stOne[S1_HDR] = 1'b0;
      evtClr = (rdS2 && (|q.stTwo)) || btfClr
               || (rdS1 && q.stOne[S1_OWN_ADDRESS_MATCHED])
               || (q.seqArmed && wrDr && q.stOne[S1_START])
               || (q.hdrArmed && wrDr && q.stOne[S1_HDR]);
      if (evtClr)
         d.stOne[S1_EVENT] = 1'b0;
      if (rdS2)
         d.stTwo = 4'h0;
      // ---- hardware sets ----
      btfSet  = (engTxDone && !engTxIsAddr) || engAddrSent
                || (engRxDone && engAckEn);
      adslSet = engRxAddrValid && engAckEn
                && (engRxAddr == q.ownAddr || engRxAddr == GENERAL_CALL);
      stopSlave = line.stopSeen && !q.stOne[S1_MASTER];
      if (btfSet)
      begin
         d.stOne[S1_BTF] = 1'b1;
         d.stOne[S1_DIR] = !engRxDone;
      end
      if (engRxDone)
         d.dataByte = engRxData;
      if (adslSet)
         d.stOne[S1_OWN_ADDRESS_MATCHED] = 1'b1;
      if (engHdrSent)
         d.stOne[S1_HDR] = 1'b1;
      if (engStartGen)
      begin
         d.stOne[S1_START]  = 1'b1;
         d.stOne[S1_MASTER] = 1'b1;
      end
      if (line.stopSeen || engArbLost)
      begin
         d.stOne[S1_DIR]    = 1'b0;
         d.stOne[S1_MASTER] = 1'b0;
      end
      // error flags, bit order noack, stop, arb lost, bus error as in the package
      d.stTwo = d.stTwo | {engNoAck, stopSlave, engArbLost, engBusErr};
      // interrupt sources, bit order header down to byte done as in the package
      irqSet = {engHdrSent, engBusErr, engArbLost, stopSlave,
                engNoAck, engStartGen, adslSet, btfSet};
      if ((|irqSet) || engAddrSent)
         d.stOne[S1_EVENT] = 1'b1;
      // busy follows the lines only while the interface is on
      if (q.ifOn)
      begin
         if (line.startSeen)
            d.stOne[S1_BUSY] = 1'b1;
         if (line.stopSeen || engBusErr)
            d.stOne[S1_BUSY] = 1'b0;
      end

      // interface off is a hardware clear and overrides any set
      if (!q.ifOn)
      begin
         d.stOne[S1_EVENT] = 1'b0;
         d.stOne[S1_HDR]   = 1'b0;
         d.stOne[S1_DIR]   = 1'b0;
         d.stOne[S1_BTF]   = 1'b0;
         d.stOne[S1_OWN_ADDRESS_MATCHED]  = 1'b0;
      end

      // sticky interrupt status: write one clears, a new event wins
      if (wrEn && q.awAddr == OFF_IRQ_STAT && q.wLane0)
         d.irqSt = q.irqSt & ~q.wByte;
      d.irqSt  = d.irqSt | irqSet;
      d.irqOut = d.intEn && (|(d.irqSt & d.irqMask));
      // stretch the clock while software owes an answer
      d.sclHold = d.stOne[S1_BTF] || d.stOne[S1_OWN_ADDRESS_MATCHED];
      // ready flags track the held halves and pending responses
      d.awRdy = !d.awHave && !d.bValid;
      d.wRdy  = !d.wHave && !d.bValid;
      d.arRdy = !d.rValid;
   end

   // ======================================================
   // registers, reset to zero except the three ready flags, which reset to one
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         q         <= '0;
         q.ownAddr <= RST_OWN_ADDR;
         q.awRdy   <= 1'b1;
         q.wRdy    <= 1'b1;
         q.arRdy   <= 1'b1;
      end
      else
         q <= d;
   end

   // ======================================================
   // outputs, all from the state register except sclOut, which is the constant 1'b0
   assign awready      = q.awRdy;
   assign wready       = q.wRdy;
   assign bvalid       = q.bValid;
   assign bresp        = q.bResp;
   assign arready      = q.arRdy;
   assign rvalid       = q.rValid;
   assign rdata        = q.rData;
   assign rresp        = q.rResp;
   assign sclOut       = 1'b0;      // open drain: only ever pulls low
   assign sclOe        = q.sclHold;
   assign interfaceOn  = q.ifOn;
   assign txByte       = q.dataByte;
   assign dataWrStrobe = q.wrPulse;
   assign dataRdStrobe = q.rdPulse;
   assign irq          = q.irqOut;

endmodule

`default_nettype wire

// >>> dv/i2sf_bus_peer.sv
// i2sf_bus_peer: another master on the two-wire bus, making start and stop.
// assumes: wired-and lines with pull-ups; the block only pulls the clock line.
`timescale 1ns/1ps
`default_nettype none

module i2sf_bus_peer
(
   input  wire logic sclOe,
   output wire logic sclIn,
   output wire logic sdaIn
);
   logic sclDrv = 1'b1; // released: pull-up wins
   logic sdaDrv = 1'b1; // released: pull-up wins
   int   n;             // stretch wait count

   // ====
   // lines
   // wired-and: whoever pulls low wins, so stretching is seen here
   assign sclIn = sclDrv & ~sclOe;
   assign sdaIn = sdaDrv;

   // ====
   // conditions
   // data falls while clock is high, then the clock is pulled low for the frame
   task start_bus;
      begin
         #400 sdaDrv = 1'b0;
         #800 sclDrv = 1'b0;
         #400;
      end
   endtask

   // release the clock, wait out stretching, then data rises while high
   task stop_bus;
      begin
         sdaDrv = 1'b0;
         #400 sclDrv = 1'b1;
         n = 0;
         while (!sclIn && n < 50) // bounded: a stuck stretch must not hang us
         begin
            #400 n++;
         end
         #400 sdaDrv = 1'b1;
         #800;
      end
   endtask
endmodule

`default_nettype wire

// >>> dv/i2sf_status_flags_assertions.sv
// i2sf_status_flags_assertions: port checks on the flag block.
// assumes: bound into i2sf_status_flags; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module i2sf_status_flags_assertions
   import i2sf_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic [31:0] rdata,
   input wire logic        awready,
   input wire logic        wready,
   input wire logic        interfaceOn,
   input wire logic        sclOut,
   input wire logic        sclOe,
   input wire logic        engTxDone,
   input wire logic        engTxIsAddr,
   input wire logic        engRxDone,
   input wire logic        engAckEn,
   input wire logic        engRxAddrValid,
   input wire logic [6:0]  engRxAddr,
   input wire logic        irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // ====
   // clock stretching
   a_tx_stretch: assert property (engTxDone && !engTxIsAddr && interfaceOn |=> sclOe)
      else $error("no tx stretch");
   a_rx_stretch: assert property (engRxDone && engAckEn && interfaceOn |=> sclOe)
      else $error("no rx stretch");
   a_gc_stretch: assert property (engRxAddrValid && engAckEn && interfaceOn
      && engRxAddr == GENERAL_CALL |=> sclOe)
      else $error("no gc stretch");
   // no software access pending: nothing may release the line
   a_stretch_hold: assert property (sclOe && interfaceOn && !arvalid && !rvalid
      && awready && wready |=> sclOe)
      else $error("early release");
   a_off_release: assert property (!interfaceOn [*2] |-> !sclOe)
      else $error("held while off");
   a_scl_low: assert property (sclOe |-> sclOut == 1'b0)
      else $error("line driven high");

   // ====
   // registers
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read unanswered");
   a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("upper bits set");
   a_reset_clean: assert property ($fell(rst) |-> !sclOe && !irq)
      else $error("reset not clean");

   c_release: cover property (sclOe ##1 !sclOe);
   c_irq: cover property (irq);
   c_match: cover property (engRxAddrValid && engAckEn);
endmodule

bind i2sf_status_flags i2sf_status_flags_assertions i2sf_status_flags_assertions_i (
   .clock(clock), .rst(rst), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rdata(rdata), .awready(awready), .wready(wready), .interfaceOn(interfaceOn),
   .sclOut(sclOut), .sclOe(sclOe), .engTxDone(engTxDone), .engTxIsAddr(engTxIsAddr),
   .engRxDone(engRxDone), .engAckEn(engAckEn), .engRxAddrValid(engRxAddrValid),
   .engRxAddr(engRxAddr), .irq(irq));

`default_nettype wire

// >>> dv/tb_i2sf_status_flags.sv
// tb_i2sf_status_flags: self-checking bench for the flag block.
// assumes: the peer model drives the raw lines; the bench is software and engine.
`timescale 1ns/1ps
`default_nettype none

module tb_i2sf_status_flags
   import i2sf_pkg::*;
;
   typedef struct packed {logic [8:0] ev; logic isA; logic [7:0] exp;} i2sf_row_t;
   logic clock, rst, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready;
   logic wready, arready, sclOut, sclOe, interfaceOn, dataWrStrobe, dataRdStrobe, irq, isA;
   logic [7:0]  awaddr, araddr, txByte;
   logic [6:0]  engRxAddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [8:0]  ev; // start,noack,arb,buserr,hdr,addr,tx,rx,match
   wire logic   sclIn, sdaIn;
   int          miscompares, compares;
   // engine pulse, tx qualifier, expected status_one
   i2sf_row_t rows [8] = '{'{9'h004, 1'b0, 8'hA8}, '{9'h004, 1'b1, 8'h00},
      '{9'h002, 1'b0, 8'h88}, '{9'h001, 1'b0, 8'h84}, '{9'h010, 1'b0, 8'hC0},
      '{9'h008, 1'b0, 8'hA8}, '{9'h080, 1'b0, 8'h80}, '{9'h100, 1'b0, 8'h83}};

   i2sf_status_flags i2sf_status_flags_i (.clock(clock), .rst(rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe),
      .engStartGen(ev[8]), .engNoAck(ev[7]), .engArbLost(ev[6]), .engBusErr(ev[5]),
      .engHdrSent(ev[4]), .engAddrSent(ev[3]), .engTxDone(ev[2]), .engTxIsAddr(isA),
      .engRxDone(ev[1]), .engRxData(8'h5A), .engAckEn(1'b1), .engRxAddrValid(ev[0]),
      .engRxAddr(engRxAddr), .interfaceOn(interfaceOn), .txByte(txByte),
      .dataWrStrobe(dataWrStrobe), .dataRdStrobe(dataRdStrobe), .irq(irq));
   i2sf_bus_peer i2sf_bus_peer_i (.sclOe(sclOe), .sclIn(sclIn), .sdaIn(sdaIn));

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ====
   // helpers
   task final_report;
      begin
         $display("compares %0d miscompares %0d", compares, miscompares);
         if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      begin
         compares++;
         if (s !== e)
         begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   // bounded wait for a handshake seen high at a rising edge
   task automatic hold(ref logic s);
      int n;
      begin
         n = 0;
         do
         begin
            @(posedge clock);
            n++;
         end while (s !== 1'b1 && n < 50);
         if (n >= 50)
         begin
            miscompares++;
            final_report();
         end
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ad;
      logic wd;
      begin
         @(posedge clock);
         awaddr <= a;
         wdata <= v;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         ad = 1'b0;
         wd = 1'b0;
         // either channel may be taken first
         repeat (50)
         begin
            if (!(ad && wd))
            begin
               @(posedge clock);
               if (awready) awvalid <= 1'b0;
               if (wready) wvalid <= 1'b0;
               ad = ad | awready;
               wd = wd | wready;
            end
         end
         hold(bvalid);
         r = bresp;
         bready <= 1'b0;
      end
   endtask
   task rd(input logic [7:0] a);
      begin
         @(posedge clock);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         hold(arready);
         arvalid <= 1'b0;
         hold(rvalid);
         d = rdata;
         r = rresp;
         rready <= 1'b0;
      end
   endtask
   task s1(input logic [7:0] m, input logic [7:0] e);
      begin
         rd(OFF_STATUS_ONE);
         chk(d & 32'(m), 32'(e));
      end
   endtask
   task pulse(input logic [8:0] v, input logic a);
      begin
         @(posedge clock);
         ev <= v;
         isA <= a;
         @(posedge clock);
         ev <= 9'h000;
         @(posedge clock);
         #1;
      end
   endtask
   task irqc(input logic e);
      begin
         repeat (3) @(posedge clock);
         #1;
         chk(32'(irq), 32'(e));
      end
   endtask
   task do_reset;
      begin
         @(posedge clock);
         rst <= 1'b1;
         repeat (12) @(posedge clock);
         rst <= 1'b0;
      end
   endtask

   // ====
   // main sequence
   initial
   begin
      {rst, awvalid, wvalid, bready, arvalid, rready, isA} = 7'h41;
      {awaddr, araddr, wdata, engRxAddr, ev} = 64'h0;
      do_reset();
      s1(8'hFF, 8'h00);
      rd(8'hFC);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(OFF_STATUS_ONE, 32'h000000FF);
      chk(32'(r), 32'(RESP_OKAY));
      s1(8'hFF, 8'h00);
      wr(OFF_CONTROL, 32'h3);
      wr(OFF_IRQ_MASK, 32'hFF);
      chk(32'(interfaceOn), 32'h1);
      foreach (rows[i])
      begin
         pulse(rows[i].ev, rows[i].isA);
         s1(8'hFF, rows[i].exp);
         wr(OFF_CONTROL, 32'h0);
         s1(8'hEC, 8'h00);
         wr(OFF_CONTROL, 32'h3);
      end
      irqc(1'b1);
      wr(OFF_IRQ_MASK, 32'h0);
      irqc(1'b0);
      wr(OFF_IRQ_MASK, 32'hFF);
      irqc(1'b1);
      wr(OFF_IRQ_STAT, 32'hFF);
      irqc(1'b0);
      // mid-run reset, then the ordered clear sequences
      do_reset();
      s1(8'hFF, 8'h00);
      wr(OFF_CONTROL, 32'h3);
      pulse(9'h004, 1'b0);
      chk(32'(sclOe), 32'h1);
      s1(8'hFF, 8'hA8);
      rd(OFF_CONTROL);
      wr(OFF_DATA, 32'h5);
      s1(8'hFF, 8'hA8);
      wr(OFF_DATA, 32'h5);
      s1(8'hFF, 8'h00);
      chk(32'(sclOe), 32'h0);
      pulse(9'h002, 1'b0);
      s1(8'hFF, 8'h88);
      rd(OFF_DATA);
      chk(d, 32'h5A);
      chk(32'(txByte), 32'h5A);
      s1(8'hFF, 8'h00);
      pulse(9'h010, 1'b0);
      s1(8'hFF, 8'hC0);
      wr(OFF_DATA, 32'h0);
      s1(8'h40, 8'h40);
      rd(OFF_STATUS_TWO);
      wr(OFF_DATA, 32'h0);
      s1(8'h40, 8'h00);
      pulse(9'h020, 1'b0);
      s1(8'h80, 8'h80);
      rd(OFF_STATUS_TWO);
      chk(d & 32'h1, 32'h1);
      s1(8'h80, 8'h00);
      wr(OFF_OWN_ADDR, 32'h2A);
      engRxAddr <= 7'h2B;
      pulse(9'h001, 1'b0);
      s1(8'h04, 8'h00);
      engRxAddr <= 7'h2A;
      pulse(9'h001, 1'b0);
      chk(32'(sclOe), 32'h1);
      s1(8'hFF, 8'h84);
      s1(8'hFF, 8'h00);
      chk(32'(sclOe), 32'h0);
      pulse(9'h004, 1'b0);
      pulse(9'h040, 1'b0);
      s1(8'h20, 8'h00);
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_CONTROL, 32'h3);
      // busy follows the lines, frozen while off
      i2sf_bus_peer_i.start_bus();
      s1(8'h10, 8'h10);
      i2sf_bus_peer_i.stop_bus();
      s1(8'h10, 8'h00);
      i2sf_bus_peer_i.start_bus();
      pulse(9'h020, 1'b0);
      s1(8'h10, 8'h00);
      wr(OFF_CONTROL, 32'h0);
      i2sf_bus_peer_i.stop_bus();
      i2sf_bus_peer_i.start_bus();
      s1(8'h10, 8'h00);
      i2sf_bus_peer_i.stop_bus();
      final_report();
   end
endmodule

`default_nettype wire
